/* src/arsq_pkg.sv */
`default_nettype none

package arsq_pkg;

   // ==========================================================
   // Sizes
   // ==========================================================
   localparam int NCYC = 5;
   localparam int NREQ = 3;
   localparam int DW = 16;
   localparam int AW = 8;
   localparam int PW = 3;
   localparam int IW = 4;

   // ==========================================================
   // Register word addresses
   // ==========================================================
   localparam logic [AW-1:0] A_CTRL = 8'h00;
   localparam logic [AW-1:0] A_FTEN = 8'h01;
   localparam logic [AW-1:0] A_FTD0 = 8'h02;
   localparam logic [AW-1:0] A_RECLAIM = 8'h05;
   localparam logic [AW-1:0] A_PROG = 8'h06;
   localparam logic [AW-1:0] A_ISTAT = 8'h07;
   localparam logic [AW-1:0] A_IMASK = 8'h08;
   localparam logic [AW-1:0] A_CYC = 8'h10;
   localparam logic [AW-1:0] A_CYC_END = 8'h24;

   // Field of a word inside one cycle's group of four.
   localparam logic [1:0] F_EN = 2'h0;
   localparam logic [1:0] F_D2 = 2'h1;
   localparam logic [1:0] F_D3 = 2'h2;
   localparam logic [1:0] F_DEAD = 2'h3;

   // Control word bits.
   localparam int B_GEN = 0;
   localparam int B_INTR = 1;

   // Interrupt status bits.
   localparam int I_RECLOSE = 0;
   localparam int I_FINAL = 1;
   localparam int I_RECLAIM = 2;
   localparam int I_ABORT = 3;

   // ==========================================================
   // Setting ranges: start delays in 10 ms, others in 100 ms
   // ==========================================================
   localparam logic [DW-1:0] START_MAX = 16'h01F4;
   localparam logic [DW-1:0] DEAD_MIN = 16'h0002;
   localparam logic [DW-1:0] DEAD_MAX = 16'h0BB8;
   localparam logic [DW-1:0] FT_MAX = 16'h0BB8;
   localparam logic [DW-1:0] ZERO_DLY = 16'h0000;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [NREQ-1:0] RST_EN = 3'h0;
   localparam logic [DW-1:0] RST_DEAD = 16'h0002;
   localparam logic [DW-1:0] RST_DLY = 16'h0000;
   localparam logic RST_GEN = 1'b0;
   localparam logic [IW-1:0] RST_IRQ = 4'h0;

   // ==========================================================
   // Timebase
   // ==========================================================
   localparam int CLK_PERIOD_NS = 10;
   localparam int FAST_TICK_NS = 10000000;
   localparam int FAST_TICK_CYC = FAST_TICK_NS / CLK_PERIOD_NS;
   localparam int SLOW_PER_FAST = 10;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_START = 3'h1,
      ST_DEAD = 3'h3,
      ST_RECLAIM = 3'h2,
      ST_FINAL = 3'h6
   } arsq_state_t;

   function automatic logic [DW-1:0] clamp(input logic [DW-1:0] v,
                                           input logic [DW-1:0] lo,
                                           input logic [DW-1:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

endpackage

`default_nettype wire

/* src/arsq_tick.sv */
`timescale 1ns/1ps
`default_nettype none

// Divides counted enables down to a one-cycle tick every DIV enables.
module arsq_tick #(
   parameter int DIV = 10
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   output logic tick_o
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   localparam logic [CW-1:0] CZERO = '0;

   logic [CW-1:0] cnt_reg;
   logic tick_reg;
   wire wrap = en_i && (cnt_reg == LAST);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= CZERO;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= wrap;
         if (wrap) begin
            cnt_reg <= CZERO;
         end else if (en_i) begin
            cnt_reg <= cnt_reg + CW'(1);
         end
      end
   end

   assign tick_o = tick_reg;
endmodule

`default_nettype wire

/* src/arsq_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// Loadable down counter; done pulses once after the count reaches zero.
module arsq_timer #(
   parameter int W = 16
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic clear_i,
   input wire logic load_i,
   input wire logic [W-1:0] value_i,
   input wire logic tick_i,
   output logic done_o
);
   logic [W-1:0] cnt_reg;
   logic run_reg;
   logic done_reg;
   wire at_zero = run_reg && (cnt_reg == '0);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= !clear_i && !load_i && at_zero;
         if (clear_i) begin
            run_reg <= 1'b0;
         end else if (load_i) begin
            cnt_reg <= value_i;
            run_reg <= 1'b1;
         end else if (at_zero) begin
            run_reg <= 1'b0;
         end else if (run_reg && tick_i) begin
            cnt_reg <= cnt_reg - W'(1);
         end
      end
   end

   assign done_o = done_reg;
endmodule

`default_nettype wire

/* src/arsq_top.sv */
// Summary of operation
// - Request one per cycle: 0 blocks, 1 starts.
// - Requests two, three per cycle: 1 starts cycle.
// - Per-cycle start delays, 0.00 to 5.00 s.
// - Dead times and reclaim, 0.2 to 300 s.
// - Per-request final trip enable bit.
// - Per-request final trip delay, 0 to 300 s.
// - Progress code: 0 idle, 1-5 cycle.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module arsq_top #(
   parameter int FAST_DIV = arsq_pkg::FAST_TICK_CYC
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [arsq_pkg::AW-1:0] addr_i,
   input wire logic [arsq_pkg::DW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [arsq_pkg::DW-1:0] rdata_o,
   input wire logic reclose_request_one_i,
   input wire logic reclose_request_two_i,
   input wire logic reclose_request_three_i,
   output logic reclose_cmd_o,
   output logic final_trip_o,
   output logic [arsq_pkg::PW-1:0] reclose_progress_code_o,
   output logic irq_o
);
   localparam int NC = arsq_pkg::NCYC;
   localparam int NR = arsq_pkg::NREQ;
   localparam int DW = arsq_pkg::DW;
   localparam int AW = arsq_pkg::AW;
   localparam int PW = arsq_pkg::PW;
   localparam int IW = arsq_pkg::IW;
   localparam logic [PW-1:0] NC_P = PW'(NC);

   // ==========================================================
   // Settings
   // ==========================================================
   logic [NR-1:0] cyc_en_reg [NC];
   logic [DW-1:0] d2_reg [NC];
   logic [DW-1:0] d3_reg [NC];
   logic [DW-1:0] dead_reg [NC];
   logic [NR-1:0] ft_en_reg;
   logic [DW-1:0] ft_dly_reg [NR];
   logic [DW-1:0] reclaim_reg;
   logic gen_reg;
   logic [IW-1:0] istat_reg;
   logic [IW-1:0] imask_reg;
   logic [DW-1:0] rdata_reg;

   // ==========================================================
   // Address decode
   // ==========================================================
   wire [AW-1:0] cyc_off = addr_i - arsq_pkg::A_CYC;
   wire [2:0] cyc_sel = cyc_off[4:2];
   wire [1:0] cyc_fld = cyc_off[1:0];
   wire cyc_hit = (addr_i >= arsq_pkg::A_CYC) && (addr_i < arsq_pkg::A_CYC_END);
   wire [AW-1:0] ft_off = addr_i - arsq_pkg::A_FTD0;
   wire [1:0] ft_sel = ft_off[1:0];
   wire ft_hit = (addr_i >= arsq_pkg::A_FTD0) && (addr_i < arsq_pkg::A_RECLAIM);
   wire wr_ctrl = wr_i && (addr_i == arsq_pkg::A_CTRL);
   wire intr_cmd = wr_ctrl && wdata_i[arsq_pkg::B_INTR];
   wire istat_wr = wr_i && (addr_i == arsq_pkg::A_ISTAT);
   wire [DW-1:0] wd_start = arsq_pkg::clamp(wdata_i, arsq_pkg::ZERO_DLY, arsq_pkg::START_MAX);
   wire [DW-1:0] wd_dead = arsq_pkg::clamp(wdata_i, arsq_pkg::DEAD_MIN, arsq_pkg::DEAD_MAX);
   wire [DW-1:0] wd_ft = arsq_pkg::clamp(wdata_i, arsq_pkg::ZERO_DLY, arsq_pkg::FT_MAX);

   // ==========================================================
   // Register writes
   // ==========================================================
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int c = 0; c < NC; c++) begin
            cyc_en_reg[c] <= arsq_pkg::RST_EN;
            d2_reg[c] <= arsq_pkg::RST_DLY;
            d3_reg[c] <= arsq_pkg::RST_DLY;
            dead_reg[c] <= arsq_pkg::RST_DEAD;
         end
         for (int r = 0; r < NR; r++) begin
            ft_dly_reg[r] <= arsq_pkg::RST_DLY;
         end
         ft_en_reg <= arsq_pkg::RST_EN;
         reclaim_reg <= arsq_pkg::RST_DEAD;
         gen_reg <= arsq_pkg::RST_GEN;
         imask_reg <= arsq_pkg::RST_IRQ;
      end else if (wr_i) begin
         if (cyc_hit) begin
            case (cyc_fld)
               arsq_pkg::F_EN: cyc_en_reg[cyc_sel] <= wdata_i[NR-1:0];
               arsq_pkg::F_D2: d2_reg[cyc_sel] <= wd_start;
               arsq_pkg::F_D3: d3_reg[cyc_sel] <= wd_start;
               default: dead_reg[cyc_sel] <= wd_dead;
            endcase
         end
         if (ft_hit) begin
            ft_dly_reg[ft_sel] <= wd_ft;
         end
         if (addr_i == arsq_pkg::A_FTEN) begin
            ft_en_reg <= wdata_i[NR-1:0];
         end
         if (addr_i == arsq_pkg::A_RECLAIM) begin
            reclaim_reg <= wd_dead;
         end
         if (addr_i == arsq_pkg::A_IMASK) begin
            imask_reg <= wdata_i[IW-1:0];
         end
         if (wr_ctrl) begin
            gen_reg <= wdata_i[arsq_pkg::B_GEN];
         end
      end
   end

   // ==========================================================
   // Request synchronisers and edge detection
   // ==========================================================
   wire [NR-1:0] req_pin = {reclose_request_three_i, reclose_request_two_i,
                            reclose_request_one_i};
   logic [NR-1:0] req_s1_reg;
   logic [NR-1:0] req_s2_reg;
   logic [NR-1:0] req_s3_reg;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_s1_reg <= '0;
         req_s2_reg <= '0;
         req_s3_reg <= '0;
      end else begin
         req_s1_reg <= req_pin;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg;
      end
   end

   wire [NR-1:0] req_rise = req_s2_reg & ~req_s3_reg;
   wire [1:0] src = req_rise[0] ? 2'h0 : (req_rise[1] ? 2'h1 : 2'h2);

   // ==========================================================
   // Timebase and sequence timer
   // ==========================================================
   logic tick_fast;
   logic tick_slow;
   logic tmr_done;

   arsq_tick #(.DIV(FAST_DIV)) u_fast (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .en_i(1'b1),
      .tick_o(tick_fast)
   );

   arsq_tick #(.DIV(arsq_pkg::SLOW_PER_FAST)) u_slow (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .en_i(tick_fast),
      .tick_o(tick_slow)
   );

   // ==========================================================
   // Sequencer
   // ==========================================================
   arsq_pkg::arsq_state_t state_reg;
   arsq_pkg::arsq_state_t state_next;
   logic [PW-1:0] shot_reg;
   logic [PW-1:0] shot_next;
   logic [1:0] src_reg;
   logic [1:0] src_next;
   logic fast_sel_reg;
   logic fast_sel_next;
   logic tmr_load;
   logic tmr_clear;
   logic [DW-1:0] tmr_value;
   logic reclose_ev;
   logic final_ev;
   logic reclaim_ev;
   logic [PW-1:0] prog_reg;
   logic reclose_reg;
   logic final_reg;

   wire [2:0] shot_idx = (shot_reg < NC_P) ? shot_reg : 3'h0;
   wire shot_left = shot_reg < NC_P;
   // The running cycle is one below the shot count, which already reaches five.
   wire [2:0] dead_idx = (shot_reg != '0) ? (shot_reg - 3'h1) : 3'h0;
   wire [NR-1:0] cur_en = cyc_en_reg[shot_idx];
   wire src_ok = shot_left && cur_en[src];
   wire can_accept = (state_reg == arsq_pkg::ST_IDLE) || (state_reg == arsq_pkg::ST_RECLAIM);
   wire accept = gen_reg && can_accept && (req_rise != '0);
   wire abort = intr_cmd || !gen_reg;
   wire tmr_tick = fast_sel_reg ? tick_fast : tick_slow;
   wire [DW-1:0] start_dly = (src == 2'h0) ? arsq_pkg::ZERO_DLY :
                             ((src == 2'h1) ? d2_reg[shot_idx] : d3_reg[shot_idx]);

   arsq_timer #(.W(DW)) u_tmr (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .clear_i(tmr_clear),
      .load_i(tmr_load),
      .value_i(tmr_value),
      .tick_i(tmr_tick),
      .done_o(tmr_done)
   );

   always_comb begin
      state_next = state_reg;
      shot_next = shot_reg;
      src_next = src_reg;
      fast_sel_next = fast_sel_reg;
      tmr_load = 1'b0;
      tmr_clear = 1'b0;
      tmr_value = arsq_pkg::ZERO_DLY;
      reclose_ev = 1'b0;
      final_ev = 1'b0;
      reclaim_ev = 1'b0;
      if (abort) begin
         state_next = arsq_pkg::ST_IDLE;
         shot_next = '0;
         tmr_clear = 1'b1;
      end else if (accept) begin
         src_next = src;
         tmr_load = 1'b1;
         if (src_ok) begin
            state_next = arsq_pkg::ST_START;
            shot_next = shot_reg + PW'(1);
            fast_sel_next = 1'b1;
            tmr_value = start_dly;
         end else if (ft_en_reg[src]) begin
            state_next = arsq_pkg::ST_FINAL;
            fast_sel_next = 1'b0;
            tmr_value = ft_dly_reg[src];
         end else begin
            state_next = arsq_pkg::ST_IDLE;
            shot_next = '0;
            tmr_load = 1'b0;
            tmr_clear = 1'b1;
         end
      end else begin
         case (state_reg)
            arsq_pkg::ST_START: begin
               if (!req_s2_reg[src_reg]) begin
                  state_next = arsq_pkg::ST_IDLE;
                  shot_next = '0;
                  tmr_clear = 1'b1;
               end else if (tmr_done) begin
                  state_next = arsq_pkg::ST_DEAD;
                  fast_sel_next = 1'b0;
                  tmr_load = 1'b1;
                  tmr_value = dead_reg[dead_idx];
               end
            end
            arsq_pkg::ST_DEAD: begin
               if (tmr_done) begin
                  state_next = arsq_pkg::ST_RECLAIM;
                  reclose_ev = 1'b1;
                  tmr_load = 1'b1;
                  tmr_value = reclaim_reg;
               end
            end
            arsq_pkg::ST_RECLAIM: begin
               if (tmr_done) begin
                  state_next = arsq_pkg::ST_IDLE;
                  shot_next = '0;
                  reclaim_ev = 1'b1;
               end
            end
            arsq_pkg::ST_FINAL: begin
               if (tmr_done) begin
                  state_next = arsq_pkg::ST_IDLE;
                  shot_next = '0;
                  final_ev = 1'b1;
               end
            end
            default: begin
               state_next = arsq_pkg::ST_IDLE;
            end
         endcase
      end
   end

   wire seq_idle = (state_next == arsq_pkg::ST_IDLE) || (state_next == arsq_pkg::ST_FINAL);
   wire [PW-1:0] prog_next = seq_idle ? '0 : shot_next;
   wire abort_ev = intr_cmd && (state_reg != arsq_pkg::ST_IDLE);
   wire [IW-1:0] irq_ev = {abort_ev, reclaim_ev, final_ev, reclose_ev};
   wire [IW-1:0] irq_clr = istat_wr ? wdata_i[IW-1:0] : '0;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= arsq_pkg::ST_IDLE;
         shot_reg <= '0;
         src_reg <= 2'h0;
         fast_sel_reg <= 1'b0;
         prog_reg <= '0;
         reclose_reg <= 1'b0;
         final_reg <= 1'b0;
         istat_reg <= arsq_pkg::RST_IRQ;
      end else begin
         state_reg <= state_next;
         shot_reg <= shot_next;
         src_reg <= src_next;
         fast_sel_reg <= fast_sel_next;
         prog_reg <= prog_next;
         reclose_reg <= reclose_ev;
         final_reg <= final_ev;
         istat_reg <= (istat_reg & ~irq_clr) | irq_ev;
      end
   end

   // ==========================================================
   // Read port
   // ==========================================================
   logic [DW-1:0] rd_mux;

   always_comb begin
      rd_mux = '0;
      if (cyc_hit) begin
         case (cyc_fld)
            arsq_pkg::F_EN: rd_mux = DW'(cyc_en_reg[cyc_sel]);
            arsq_pkg::F_D2: rd_mux = d2_reg[cyc_sel];
            arsq_pkg::F_D3: rd_mux = d3_reg[cyc_sel];
            default: rd_mux = dead_reg[cyc_sel];
         endcase
      end else if (ft_hit) begin
         rd_mux = ft_dly_reg[ft_sel];
      end else begin
         case (addr_i)
            arsq_pkg::A_CTRL: rd_mux = DW'(gen_reg);
            arsq_pkg::A_FTEN: rd_mux = DW'(ft_en_reg);
            arsq_pkg::A_RECLAIM: rd_mux = reclaim_reg;
            arsq_pkg::A_PROG: rd_mux = DW'(prog_reg);
            arsq_pkg::A_ISTAT: rd_mux = DW'(istat_reg);
            arsq_pkg::A_IMASK: rd_mux = DW'(imask_reg);
            default: rd_mux = '0;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rd_i ? rd_mux : '0;
      end
   end

   assign rdata_o = rdata_reg;
   assign reclose_cmd_o = reclose_reg;
   assign final_trip_o = final_reg;
   assign reclose_progress_code_o = prog_reg;
   assign irq_o = |(istat_reg & imask_reg);

   // ==========================================================
   // Assertions
   // ==========================================================
   property p_prog_idle;
      @(posedge clock_i) disable iff (!rst_n_i)
      (state_reg == arsq_pkg::ST_IDLE) |-> (reclose_progress_code_o == '0);
   endproperty
   a_prog_idle: assert property (p_prog_idle) else $error("progress not zero when idle");

   property p_prog_range;
      @(posedge clock_i) disable iff (!rst_n_i)
      (reclose_progress_code_o <= NC_P) &&
      ((state_reg == arsq_pkg::ST_DEAD) -> (reclose_progress_code_o == shot_reg));
   endproperty
   a_prog_range: assert property (p_prog_range) else $error("progress code wrong");

   property p_reclose_dead;
      @(posedge clock_i) disable iff (!rst_n_i)
      $rose(reclose_cmd_o) |-> ($past(state_reg, 2) == arsq_pkg::ST_DEAD) &&
      (state_reg == arsq_pkg::ST_RECLAIM);
   endproperty
   a_reclose_dead: assert property (p_reclose_dead) else $error("reclose not after dead");

   property p_abort;
      @(posedge clock_i) disable iff (!rst_n_i)
      intr_cmd |=> (state_reg == arsq_pkg::ST_IDLE) && !reclose_cmd_o ##1 !reclose_cmd_o;
   endproperty
   a_abort: assert property (p_abort) else $error("interruption did not abort");

   property p_block_one;
      @(posedge clock_i) disable iff (!rst_n_i)
      (accept && !abort && req_rise[0] && !cur_en[0]) |=> (state_reg != arsq_pkg::ST_START);
   endproperty
   a_block_one: assert property (p_block_one) else $error("blocked cycle started");

   property p_start_req;
      @(posedge clock_i) disable iff (!rst_n_i)
      (accept && !abort && shot_left && cur_en[src]) |=>
      (state_reg == arsq_pkg::ST_START) && (shot_reg == $past(shot_reg) + PW'(1));
   endproperty
   a_start_req: assert property (p_start_req) else $error("enabled request did not start");

   property p_final_en;
      @(posedge clock_i) disable iff (!rst_n_i)
      final_trip_o |-> ft_en_reg[src_reg] && ($past(state_reg, 2) == arsq_pkg::ST_FINAL);
   endproperty
   a_final_en: assert property (p_final_en) else $error("final trip not enabled");

   property p_ranges;
      @(posedge clock_i) disable iff (!rst_n_i)
      (dead_reg[0] >= arsq_pkg::DEAD_MIN) && (dead_reg[0] <= arsq_pkg::DEAD_MAX) &&
      (reclaim_reg >= arsq_pkg::DEAD_MIN) && (d2_reg[0] <= arsq_pkg::START_MAX);
   endproperty
   a_ranges: assert property (p_ranges) else $error("setting out of range");

   property p_ft_range;
      @(posedge clock_i) disable iff (!rst_n_i)
      (d3_reg[4] <= arsq_pkg::START_MAX) && (ft_dly_reg[2] <= arsq_pkg::FT_MAX);
   endproperty
   a_ft_range: assert property (p_ft_range) else $error("delay out of range");

endmodule

`default_nettype wire

/* sim/arsq_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none

module arsq_stage_model (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [2:0] fire_i,
   input wire logic [15:0] hold_i,
   output logic req_one_o,
   output logic req_two_o,
   output logic req_three_o
);
   // ==========================================================
   // Request pattern held for a commanded number of cycles
   // ==========================================================
   logic [2:0] mask_reg;
   logic [15:0] left_reg;
   logic live;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_reg <= 3'h0;
         left_reg <= 16'h0000;
      end else if (fire_i != 3'h0) begin
         mask_reg <= fire_i;
         left_reg <= hold_i;
      end else if (left_reg != 16'h0000) begin
         left_reg <= left_reg - 16'h0001;
      end
   end

   assign live = (left_reg != 16'h0000);
   assign req_one_o = mask_reg[0] && live;
   assign req_two_o = mask_reg[1] && live;
   assign req_three_o = mask_reg[2] && live;
endmodule

`default_nettype wire

/* sim/arsq_top_test.sv */
`timescale 1ns/1ps
`default_nettype none

module arsq_top_test;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [15:0] rdata_o;
   logic req1, req2, req3, reclose_cmd_o, final_trip_o, irq_o;
   logic [2:0] prog;
   logic [2:0] fire = 3'h0;
   logic [15:0] hold = 16'h0000;
   logic [15:0] rc_cnt = 16'h0000;
   logic [15:0] ft_cnt = 16'h0000;
   int fails = 0;
   int comparisons = 0;

   always #5 clock_i = ~clock_i;

   arsq_top #(.FAST_DIV(10)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .reclose_request_one_i(req1), .reclose_request_two_i(req2),
      .reclose_request_three_i(req3), .reclose_cmd_o(reclose_cmd_o),
      .final_trip_o(final_trip_o), .reclose_progress_code_o(prog), .irq_o(irq_o));

   arsq_stage_model stage_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .fire_i(fire),
      .hold_i(hold), .req_one_o(req1), .req_two_o(req2), .req_three_o(req3));

   // ==========================================================
   // Pulse counters
   // ==========================================================
   always @(posedge clock_i) begin
      if (reclose_cmd_o === 1'b1) rc_cnt <= rc_cnt + 16'h0001;
      if (final_trip_o === 1'b1) ft_cnt <= ft_cnt + 16'h0001;
   end

   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic test_done();
      if (fails == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [15:0] exp);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      chk(name, exp, rdata_o);
   endtask

   task automatic req(input logic [2:0] m, input logic [15:0] h);
      @(posedge clock_i);
      fire <= m;
      hold <= h;
      @(posedge clock_i);
      fire <= 3'h0;
      #1;
   endtask

   function automatic logic [15:0] obs(input int sel);
      if (sel == 0) return {13'h0000, prog};
      if (sel == 1) return rc_cnt;
      return ft_cnt;
   endfunction

   // Polls one observed value, giving up after the bound.
   task automatic wait_val(input string name, input int sel, input logic [15:0] exp,
                           input int bound);
      int i;
      for (i = 0; i < bound; i++) begin
         if (obs(sel) === exp) break;
         @(posedge clock_i);
         #1;
      end
      chk(name, exp, obs(sel));
      if (i == bound) test_done();
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd_chk("reclaim", arsq_pkg::A_RECLAIM, arsq_pkg::RST_DEAD);
      rd_chk("dead1", arsq_pkg::A_CYC + 8'h03, arsq_pkg::RST_DEAD);
      rd_chk("ften", arsq_pkg::A_FTEN, 16'h0000);
      rd_chk("prog", arsq_pkg::A_PROG, 16'h0000);
      rd_chk("unmapped", 8'h30, 16'h0000);
      wr(arsq_pkg::A_CYC + 8'h01, 16'hFFFF);
      rd_chk("d2 max", arsq_pkg::A_CYC + 8'h01, arsq_pkg::START_MAX);
      wr(arsq_pkg::A_CYC + 8'h12, 16'h01F4);
      rd_chk("c5 d3", arsq_pkg::A_CYC + 8'h12, 16'h01F4);
      wr(arsq_pkg::A_CYC + 8'h03, 16'hFFFF);
      rd_chk("dead max", arsq_pkg::A_CYC + 8'h03, arsq_pkg::DEAD_MAX);
      wr(arsq_pkg::A_CYC + 8'h03, 16'h0000);
      rd_chk("dead min", arsq_pkg::A_CYC + 8'h03, arsq_pkg::DEAD_MIN);
      wr(arsq_pkg::A_FTD0 + 8'h02, 16'hFFFF);
      rd_chk("ft max", arsq_pkg::A_FTD0 + 8'h02, arsq_pkg::FT_MAX);
      // A request while the function is switched off is ignored.
      wr(arsq_pkg::A_CYC, 16'h0001);
      req(3'h1, 16'h0005);
      repeat (20) @(posedge clock_i);
      #1;
      chk("off prog", 16'h0000, obs(0));
      wr(arsq_pkg::A_CYC + 8'h04, 16'h0001);
      wr(arsq_pkg::A_CYC + 8'h07, 16'h0002);
      wr(arsq_pkg::A_RECLAIM, 16'h000A);
      wr(arsq_pkg::A_CTRL, 16'h0001);
      req(3'h1, 16'h0005);
      wait_val("prog c1", 0, 16'h0001, 40);
      wait_val("reclose 1", 1, 16'h0001, 600);
      chk("reclaim prog", 16'h0001, obs(0));
      req(3'h1, 16'h0005);
      wait_val("prog c2", 0, 16'h0002, 40);
      wait_val("reclose 2", 1, 16'h0002, 600);
      wait_val("idle", 0, 16'h0000, 1500);
      rd_chk("istat", arsq_pkg::A_ISTAT, 16'h0005);
      chk("irq masked", 16'h0000, {15'h0000, irq_o});
      wr(arsq_pkg::A_IMASK, 16'h000F);
      chk("irq", 16'h0001, {15'h0000, irq_o});
      wr(arsq_pkg::A_ISTAT, 16'h000F);
      rd_chk("istat clr", arsq_pkg::A_ISTAT, 16'h0000);
      chk("irq clr", 16'h0000, {15'h0000, irq_o});
      // Second request starts only through its own start delay.
      wr(arsq_pkg::A_CYC, 16'h0002);
      wr(arsq_pkg::A_CYC + 8'h01, 16'h0005);
      req(3'h2, 16'h000A);
      wait_val("req2 start", 0, 16'h0001, 40);
      wait_val("req2 drop", 0, 16'h0000, 100);
      chk("no reclose", 16'h0002, rc_cnt);
      req(3'h2, 16'h0064);
      wait_val("req2 reclose", 1, 16'h0003, 800);
      wait_val("idle 2", 0, 16'h0000, 1500);
      req(3'h4, 16'h0064);
      repeat (100) @(posedge clock_i);
      #1;
      chk("req3 off", 16'h0000, obs(0));
      // Blocked cycle leads to final trip where enabled.
      wr(arsq_pkg::A_CYC, 16'h0000);
      wr(arsq_pkg::A_FTEN, 16'h0001);
      wr(arsq_pkg::A_FTD0, 16'h0000);
      req(3'h1, 16'h0005);
      wait_val("final 1", 2, 16'h0001, 300);
      chk("blocked", 16'h0003, rc_cnt);
      req(3'h2, 16'h0005);
      repeat (300) @(posedge clock_i);
      #1;
      chk("final off", 16'h0001, ft_cnt);
      // Two slow ticks keep the trip at least one full tick away.
      wr(arsq_pkg::A_FTD0, 16'h0002);
      req(3'h1, 16'h0005);
      repeat (60) @(posedge clock_i);
      #1;
      chk("final early", 16'h0001, ft_cnt);
      wait_val("final 2", 2, 16'h0002, 300);
      // Interruption aborts a cycle in its start state, before the dead time.
      wr(arsq_pkg::A_CYC, 16'h0001);
      wr(arsq_pkg::A_CYC + 8'h03, 16'h0002);
      wr(arsq_pkg::A_ISTAT, 16'h000F);
      req(3'h1, 16'h0005);
      wait_val("prog int", 0, 16'h0001, 40);
      wr(arsq_pkg::A_CTRL, 16'h0003);
      wait_val("aborted", 0, 16'h0000, 5);
      rd_chk("ctrl", arsq_pkg::A_CTRL, 16'h0001);
      rd_chk("istat abort", arsq_pkg::A_ISTAT, 16'h0008);
      repeat (400) @(posedge clock_i);
      #1;
      chk("no reclose int", 16'h0003, rc_cnt);
      test_done();
   end
endmodule

`default_nettype wire
